// ===== bcu_asserts.sv
// port checker for the branch condition unit
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
// ====
// checker
module bcu_asserts #(
	parameter CM_WORDS = 128,
	parameter AW = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// bus and memory
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire mem_req_o,
	input wire mem_we_o,
	input wire mem_half_o,
	input wire [AW-1:0] mem_addr_o,
	input wire [35:0] mem_wdata_o,
	input wire mem_ack_i,
	// state
	input wire stopped_o,
	input wire busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a:
	assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_latency_a:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	req_hold_a:
	assert property (mem_req_o && !mem_ack_i |=> mem_req_o
		&& $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("memory request changed early");
	half_write_a:
	assert property (mem_req_o && mem_we_o |-> mem_half_o
		&& mem_wdata_o[35:16] == 20'h0)
		else $error("return store not a clean half write");
	write_fetch_a:
	assert property (mem_req_o && mem_we_o && mem_ack_i |=> mem_req_o
		&& !mem_we_o && mem_addr_o == $past(mem_addr_o) + 1'b1)
		else $error("no fetch of target plus one");
	fetch_done_a:
	assert property (mem_req_o && mem_ack_i && !mem_we_o |=>
		!busy_o && !mem_req_o)
		else $error("busy after fetch answer");
	idle_quiet_a:
	assert property (!busy_o |-> !mem_req_o)
		else $error("memory request while idle");
	stop_quiet_a:
	assert property (stopped_o |-> !mem_req_o)
		else $error("memory request while stopped");
	start_fetch_a:
	assert property ($rose(busy_o) |-> ##[1:3] (mem_req_o || stopped_o))
		else $error("no fetch after start");
	cover property (mem_req_o && mem_we_o && mem_ack_i);
	cover property (stopped_o);
	cover property (mem_req_o && mem_ack_i && !mem_we_o);
endmodule
bind bcu_branch_condition_unit bcu_asserts #(.CM_WORDS(CM_WORDS), .AW(AW))
	bcu_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
	.mem_we_o(mem_we_o), .mem_half_o(mem_half_o), .mem_addr_o(mem_addr_o),
	.mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
	.stopped_o(stopped_o), .busy_o(busy_o));

// ===== bcu_branch_condition_unit.v
// branch condition unit: jump decision, side-effect writes, next fetch
// assumes a core memory port that answers mem_req_o with mem_ack_i
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "bcu_consts.vh"

module bcu_branch_condition_unit #(
	parameter CM_WORDS = 128,
	parameter AW = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// core memory port
	output wire mem_req_o,
	output wire mem_we_o,
	output wire mem_half_o,
	output wire [AW-1:0] mem_addr_o,
	output wire [35:0] mem_wdata_o,
	input wire mem_ack_i,
	input wire [35:0] mem_rdata_i,
	// operator console
	input wire [3:0] console_key_i,
	input wire [3:0] stop_key_i,
	input wire restart_i,
	// arithmetic flag sources
	input wire arith_done_i,
	input wire [5:0] arith_op_i,
	input wire arith_ovf_i,
	input wire arith_carry_i,
	// state
	output wire stopped_o,
	output wire busy_o
);

// ==========================================================
// helpers
function [35:0] add36;
	input [35:0] x;
	input [35:0] y;
	reg [36:0] s;
	begin
		s = {1'b0, x} + {1'b0, y};
		add36 = s[35:0] + {35'h0, s[36]};
	end
endfunction

function [17:0] add18;
	input [17:0] x;
	input [17:0] y;
	reg [18:0] s;
	begin
		s = {1'b0, x} + {1'b0, y};
		add18 = s[17:0] + {17'h0, s[18]};
	end
endfunction

function [31:0] wmerge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] sel;
	integer k;
	begin
		wmerge = old;
		for (k = 0; k < 4; k = k + 1) begin
			if (sel[k])
				wmerge[k*8 +: 8] = nw[k*8 +: 8];
		end
	end
endfunction

// ==========================================================
// states
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_EXEC = 3'd1;
localparam [2:0] S_CORE = 3'd2;
localparam [2:0] S_STOP = 3'd3;
localparam [2:0] S_FETCH = 3'd4;

reg [2:0] st_q;
reg [35:0] cm_q [0:CM_WORDS-1];
reg [31:0] instr_q;
reg [AW-1:0] p_q;
reg [6:0] cmidx_q;
reg [35:0] ihold_q;
reg ovf_q;
reg carry_q;
reg jumped_q;
reg ill_q;
reg [AW-1:0] tgt_q;
reg ack_q;
reg [31:0] dat_q;
reg req_q;
reg we_q;
reg [AW-1:0] addr_q;
reg [35:0] wdata_q;

// ==========================================================
// instruction fields and control memory read
wire [5:0] op = instr_q[`BCU_F_OP];
wire [3:0] fj = instr_q[`BCU_F_J];
wire [3:0] fa = instr_q[`BCU_F_A];
wire [AW-1:0] fu = instr_q[`BCU_F_U];
wire [AW-1:0] fu1 = fu + {{(AW-1){1'b0}}, 1'b1};

reg [6:0] cm_idx_c;
wire [35:0] rd = cm_q[cm_idx_c];
wire [17:0] rd_mod = rd[17:0];
wire [17:0] rd_inc = rd[35:18];
wire rd_zero = (rd == 36'h0) || (&rd);
wire rd_pos = !rd[35] && (rd != 36'h0);
wire mod_pos = !rd_mod[17] && (rd_mod != 18'h0);
wire film_u = ({1'b0, fu} < `BCU_FILM_WORDS);

// ==========================================================
// execute decision
reg jump_c;
reg [AW-1:0] tgt_c;
reg cmw_c;
reg [35:0] cmd_c;
reg corew_c;
reg stop_c;
reg ill_c;

always @* begin
	jump_c = 1'b0;
	tgt_c = fu;
	cmw_c = 1'b0;
	cmd_c = rd;
	corew_c = 1'b0;
	stop_c = 1'b0;
	ill_c = 1'b0;
	cm_idx_c = `BCU_A_BASE + {3'h0, fa};
	case (op)
	`BCU_OP_CTRJ: begin
		cm_idx_c = {fj[2:0], fa};
		jump_c = rd_pos;
		cmw_c = 1'b1;
		cmd_c = add36(rd, `BCU_MINUS_ONE);
	end
	`BCU_OP_72: begin
		case (fj)
		`BCU_J72_RET: begin
			cm_idx_c = fu[6:0];
			jump_c = 1'b1;
			tgt_c = fu1;
			if (film_u) begin
				cmw_c = 1'b1;
				cmd_c = {{(36-AW){1'b0}}, p_q};
			end else begin
				corew_c = 1'b1;
			end
		end
		`BCU_J72_ROT: begin
			jump_c = rd[35];
			cmw_c = 1'b1;
			cmd_c = {rd[34:0], rd[35]};
		end
		default: ill_c = 1'b1;
		endcase
	end
	`BCU_OP_74: begin
		case (fj)
		`BCU_J_ZERO: jump_c = rd_zero;
		`BCU_J_NZERO: jump_c = !rd_zero;
		`BCU_J_NNEG: jump_c = !rd[35];
		`BCU_J_NEG: jump_c = rd[35];
		`BCU_J_CONS: jump_c = (fa == 4'h0) || (fa == console_key_i);
		`BCU_J_STOP: begin
			jump_c = 1'b1;
			stop_c = (fa == 4'h0) || |(fa & stop_key_i);
		end
		`BCU_J_EVEN: jump_c = !rd[0];
		`BCU_J_ODD: jump_c = rd[0];
		`BCU_J_MOD: begin
			cm_idx_c = {3'h0, fa};
			jump_c = mod_pos;
			cmw_c = 1'b1;
			cmd_c = {rd_inc, add18(rd_mod, rd_inc)};
		end
		`BCU_J_LINK: begin
			cm_idx_c = {3'h0, fa};
			jump_c = 1'b1;
			cmw_c = 1'b1;
			cmd_c = {rd_inc, {(18-AW){1'b0}}, p_q};
		end
		`BCU_J_OVF: jump_c = ovf_q;
		`BCU_J_CY: jump_c = carry_q;
		`BCU_J_NCY: jump_c = !carry_q;
		default: ill_c = 1'b1;
		endcase
	end
	default: ill_c = 1'b1;
	endcase
end

// ==========================================================
// wishbone decode
wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
wire bus_wr = bus_req && wb_we_i;
wire wr_ctrl = bus_wr && (wb_adr_i == `BCU_REG_CTRL);
wire start_w = wr_ctrl && wb_sel_i[0] && wb_dat_i[`BCU_CTRL_START];
wire rst_w = wr_ctrl && wb_sel_i[0] && wb_dat_i[`BCU_CTRL_RESTART];
wire wr_fl = bus_wr && (wb_adr_i == `BCU_REG_FLAGS) && wb_sel_i[0];
wire idle = (st_q == S_IDLE);
wire [35:0] cm_sw = cm_q[cmidx_q];
wire [31:0] st_word = {28'h0, ill_q, jumped_q,
	(st_q == S_STOP), !idle};
wire [31:0] p_ext = {{(32-AW){1'b0}}, p_q};
wire [31:0] p_mrg = wmerge(p_ext, wb_dat_i, wb_sel_i);

reg [31:0] rdata_c;
always @* begin
	case (wb_adr_i)
	`BCU_REG_CTRL: rdata_c = st_word;
	`BCU_REG_INSTR: rdata_c = instr_q;
	`BCU_REG_PADDR: rdata_c = p_ext;
	`BCU_REG_CMIDX: rdata_c = {25'h0, cmidx_q};
	`BCU_REG_CMLO: rdata_c = {14'h0, cm_sw[17:0]};
	`BCU_REG_CMHI: rdata_c = {14'h0, cm_sw[35:18]};
	`BCU_REG_IHLO: rdata_c = {14'h0, ihold_q[17:0]};
	`BCU_REG_IHHI: rdata_c = {14'h0, ihold_q[35:18]};
	`BCU_REG_FLAGS: rdata_c = {30'h0, carry_q, ovf_q};
	default: rdata_c = 32'h0;
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		ack_q <= 1'b0;
		dat_q <= 32'h0;
	end else begin
		ack_q <= bus_req;
		if (bus_req)
			dat_q <= rdata_c;
	end
end

// ==========================================================
// software-writable registers, locked while busy
always @(posedge clk_i) begin
	if (rst_i) begin
		instr_q <= 32'h0;
		cmidx_q <= 7'h0;
	end else if (bus_wr && idle) begin
		if (wb_adr_i == `BCU_REG_INSTR)
			instr_q <= wmerge(instr_q, wb_dat_i, wb_sel_i);
		if (wb_adr_i == `BCU_REG_CMIDX && wb_sel_i[0])
			cmidx_q <= wb_dat_i[6:0];
	end
end

// ==========================================================
// control memory writes: execution or software
reg [31:0] cm_mrg;
always @* begin
	if (wb_adr_i == `BCU_REG_CMLO)
		cm_mrg = wmerge({14'h0, cm_sw[17:0]}, wb_dat_i, wb_sel_i);
	else
		cm_mrg = wmerge({14'h0, cm_sw[35:18]}, wb_dat_i, wb_sel_i);
end

always @(posedge clk_i) begin
	if (st_q == S_EXEC && cmw_c)
		cm_q[cm_idx_c] <= cmd_c;
	else if (bus_wr && idle && wb_adr_i == `BCU_REG_CMLO)
		cm_q[cmidx_q] <= {cm_sw[35:18], cm_mrg[17:0]};
	else if (bus_wr && idle && wb_adr_i == `BCU_REG_CMHI)
		cm_q[cmidx_q] <= {cm_mrg[17:0], cm_sw[17:0]};
end

// ==========================================================
// arithmetic flags: hardware set wins over software clear
wire ovf_op = ((arith_op_i >= `BCU_OVF_LO) && (arith_op_i <= `BCU_OVF_HI))
	|| (arith_op_i == `BCU_OVF_X1) || (arith_op_i == `BCU_OVF_X2);

always @(posedge clk_i) begin
	if (rst_i) begin
		ovf_q <= 1'b0;
		carry_q <= 1'b0;
	end else begin
		if (arith_done_i && arith_ovf_i && ovf_op)
			ovf_q <= 1'b1;
		else if (wr_fl && wb_dat_i[`BCU_FL_OVF])
			ovf_q <= 1'b0;
		if (arith_done_i)
			carry_q <= arith_carry_i;
		else if (wr_fl && wb_dat_i[`BCU_FL_CARRY])
			carry_q <= 1'b0;
	end
end

// ==========================================================
// sequencer
always @(posedge clk_i) begin
	if (rst_i) begin
		st_q <= S_IDLE;
		p_q <= `BCU_P_RST;
		tgt_q <= {AW{1'b0}};
		ihold_q <= 36'h0;
		jumped_q <= 1'b0;
		ill_q <= 1'b0;
		req_q <= 1'b0;
		we_q <= 1'b0;
		addr_q <= {AW{1'b0}};
		wdata_q <= 36'h0;
	end else begin
		case (st_q)
		S_IDLE: begin
			if (bus_wr && wb_adr_i == `BCU_REG_PADDR)
				p_q <= p_mrg[AW-1:0];
			if (start_w)
				st_q <= S_EXEC;
		end
		S_EXEC: begin
			jumped_q <= jump_c;
			ill_q <= ill_c;
			tgt_q <= jump_c ? tgt_c : p_q;
			if (stop_c) begin
				st_q <= S_STOP;
			end else if (corew_c) begin
				req_q <= 1'b1;
				we_q <= 1'b1;
				addr_q <= fu;
				wdata_q <= {18'h0, {(18-AW){1'b0}}, p_q};
				st_q <= S_CORE;
			end else begin
				if (jump_c)
					p_q <= tgt_c;
				req_q <= 1'b1;
				we_q <= 1'b0;
				addr_q <= jump_c ? tgt_c : p_q;
				st_q <= S_FETCH;
			end
		end
		S_STOP: begin
			if (restart_i || rst_w) begin
				p_q <= tgt_q;
				req_q <= 1'b1;
				we_q <= 1'b0;
				addr_q <= tgt_q;
				st_q <= S_FETCH;
			end
		end
		S_CORE: begin
			if (mem_ack_i) begin
				p_q <= tgt_q;
				we_q <= 1'b0;
				addr_q <= tgt_q;
				st_q <= S_FETCH;
			end
		end
		S_FETCH: begin
			if (mem_ack_i) begin
				req_q <= 1'b0;
				ihold_q <= mem_rdata_i;
				p_q <= p_q + {{(AW-1){1'b0}}, 1'b1};
				st_q <= S_IDLE;
			end
		end
		default: st_q <= S_IDLE;
		endcase
	end
end

// ==========================================================
// outputs
assign wb_ack_o = ack_q;
assign wb_dat_o = dat_q;
assign mem_req_o = req_q;
assign mem_we_o = we_q;
assign mem_half_o = we_q;
assign mem_addr_o = addr_q;
assign mem_wdata_o = wdata_q;
assign stopped_o = (st_q == S_STOP);
assign busy_o = !idle;

endmodule

// ===== bcu_consts.vh
// named constants for the branch condition unit
// assumes 36-bit words, 16-bit core addresses, 32-bit wishbone data
`ifndef BCU_CONSTS_VH
`define BCU_CONSTS_VH

// ==========================================================
// register offsets (byte addresses)
`define BCU_REG_CTRL 8'h00
`define BCU_REG_INSTR 8'h04
`define BCU_REG_PADDR 8'h08
`define BCU_REG_CMIDX 8'h0c
`define BCU_REG_CMLO 8'h10
`define BCU_REG_CMHI 8'h14
`define BCU_REG_IHLO 8'h18
`define BCU_REG_IHHI 8'h1c
`define BCU_REG_FLAGS 8'h20

// ==========================================================
// control and status bits
`define BCU_CTRL_START 0
`define BCU_CTRL_RESTART 1
`define BCU_ST_BUSY 0
`define BCU_ST_STOPPED 1
`define BCU_ST_JUMPED 2
`define BCU_ST_ILLEGAL 3
`define BCU_FL_OVF 0
`define BCU_FL_CARRY 1

// ==========================================================
// instruction image fields
`define BCU_F_OP 29:24
`define BCU_F_J 23:20
`define BCU_F_A 19:16
`define BCU_F_U 15:0

// ==========================================================
// operation codes (octal 70, 72, 74)
`define BCU_OP_CTRJ 6'h38
`define BCU_OP_72 6'h3a
`define BCU_OP_74 6'h3c

// minor codes
`define BCU_J72_RET 4'h1
`define BCU_J72_ROT 4'h3
`define BCU_J_ZERO 4'h0
`define BCU_J_NZERO 4'h1
`define BCU_J_NNEG 4'h2
`define BCU_J_NEG 4'h3
`define BCU_J_CONS 4'h4
`define BCU_J_STOP 4'h5
`define BCU_J_EVEN 4'h8
`define BCU_J_ODD 4'h9
`define BCU_J_MOD 4'ha
`define BCU_J_LINK 4'hb
`define BCU_J_OVF 4'hc
`define BCU_J_CY 4'he
`define BCU_J_NCY 4'hf

// ==========================================================
// overflow-capable opcodes: octal 14..21, 24, 25
`define BCU_OVF_LO 6'h0c
`define BCU_OVF_HI 6'h11
`define BCU_OVF_X1 6'h14
`define BCU_OVF_X2 6'h15

// ==========================================================
// memory layout and reset values
`define BCU_FILM_WORDS 17'h00080
`define BCU_A_BASE 7'h0c
`define BCU_P_RST 16'h0000
`define BCU_MINUS_ONE 36'hffffffffe
`endif

// ===== bcu_core_model.sv
// core memory model answering the unit's memory port
// assumes requests held until answered
`timescale 1ns/100ps
// ====
// core memory
module bcu_core_model (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// request side
	input wire req_i,
	input wire we_i,
	input wire [15:0] addr_i,
	input wire [35:0] wdata_i,
	input wire slow_i,
	// answer side
	output logic ack_o,
	output logic [35:0] rdata_o,
	// last accesses
	output logic [15:0] wa_o,
	output logic [35:0] wd_o,
	output logic [15:0] ra_o
);
	logic [3:0] wait_q;
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			wait_q <= 4'h0;
			rdata_o <= 36'h0;
		end else if (req_i && !ack_o) begin
			if (wait_q < (slow_i ? 4'h4 : 4'h0)) begin
				wait_q <= wait_q + 4'h1;
			end else begin
				wait_q <= 4'h0;
				ack_o <= 1'b1;
				if (we_i) begin
					wa_o <= addr_i;
					wd_o <= wdata_i;
				end else begin
					ra_o <= addr_i;
					rdata_o <= {20'h5a5a5, addr_i};
				end
			end
		end
	end
endmodule

// ===== tb_branch_condition_unit.sv
// testbench for the branch condition unit
// assumes the core model answers every memory request
`timescale 1ns/100ps
// ====
// bench top
module tb_branch_condition_unit;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0, stb = 0, we = 0, rk = 0, ad = 0, ov = 0, cy = 0, sl = 0;
	logic [7:0] adr = 0;
	logic [31:0] dat = 0;
	logic [31:0] rdq;
	logic [35:0] rv;
	logic [3:0] ck = 4'h3;
	logic [3:0] sk = 4'h2;
	logic [5:0] aop = 0;
	wire ack, mreq, mwe, mack, stp_o;
	wire [15:0] maddr, wa, ra;
	wire [35:0] mwd, mrd, wd;
	int errors = 0;
	int tests_run = 0;
	localparam logic [5:0] N = 6'h3c;
	always #5 clk_i = ~clk_i;
	bcu_branch_condition_unit bcu_branch_condition_unit_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdq), .wb_ack_o(ack), .mem_req_o(mreq), .mem_we_o(mwe),
		.mem_half_o(), .mem_addr_o(maddr), .mem_wdata_o(mwd),
		.mem_ack_i(mack), .mem_rdata_i(mrd), .console_key_i(ck),
		.stop_key_i(sk), .restart_i(rk), .arith_done_i(ad),
		.arith_op_i(aop), .arith_ovf_i(ov), .arith_carry_i(cy),
		.stopped_o(stp_o), .busy_o());
	bcu_core_model bcu_core_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.req_i(mreq), .we_i(mwe), .addr_i(maddr), .wdata_i(mwd),
		.slow_i(sl), .ack_o(mack), .rdata_o(mrd), .wa_o(wa), .wd_o(wd),
		.ra_o(ra));
	task print_verdict;
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		n = 0;
		do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
		{cyc, stb} <= 2'b00;
		if (n == 50) errors++;
	endtask
	task cmw(input logic [6:0] ix, input logic [35:0] v);
		wb(1, 8'h0c, {25'h0, ix});
		wb(1, 8'h10, {14'h0, v[17:0]});
		wb(1, 8'h14, {14'h0, v[35:18]});
	endtask
	task cmr(input logic [6:0] ix);
		wb(1, 8'h0c, {25'h0, ix});
		wb(0, 8'h10, 32'h0);
		rv[17:0] = rdq[17:0];
		wb(0, 8'h14, 32'h0);
		rv[35:18] = rdq[17:0];
	endtask
	task go(input logic [5:0] op, input logic [3:0] j, input logic [3:0] a,
		input logic [15:0] u);
		wb(1, 8'h08, 32'h200);
		wb(1, 8'h04, {2'b0, op, j, a, u});
		wb(1, 8'h00, 32'h1);
	endtask
	task waitidle;
		int n;
		n = 0;
		do begin
			wb(0, 8'h00, 32'h0);
			n++;
		end while (rdq[0] !== 1'b0 && n < 40);
		if (rdq[0] !== 1'b0) errors++;
	endtask
	task jp(input logic [15:0] p, input logic jm);
		wb(0, 8'h08, 32'h0);
		chk("paddr", p, rdq[15:0]);
		wb(0, 8'h00, 32'h0);
		chk("jumped", jm, rdq[2]);
		wb(0, 8'h18, 32'h0);
		chk("hold", p - 16'h1, rdq[15:0]);
	endtask
	task ex(input logic [5:0] op, input logic [3:0] j, input logic [3:0] a,
		input logic [6:0] ix, input logic [35:0] v, input logic jm,
		input logic [35:0] af);
		cmw(ix, v);
		go(op, j, a, 16'h0400);
		waitidle;
		jp(jm ? 16'h0401 : 16'h0201, jm);
		cmr(ix);
		chk("cm", af, rv);
	endtask
	task ret(input logic [15:0] u);
		go(6'h3a, 4'h1, 4'h0, u);
		waitidle;
		jp(u + 16'h2, 1'b1);
	endtask
	task stop_run(input logic [3:0] a, input logic sw);
		go(N, 4'h5, a, 16'h0400);
		wb(0, 8'h00, 32'h0);
		chk("stopped", 1'b1, stp_o);
		chk("st_bit", 1'b1, rdq[1]);
		if (sw) begin
			wb(1, 8'h00, 32'h2);
		end else begin
			@(posedge clk_i);
			rk <= 1'b1;
			@(posedge clk_i);
			rk <= 1'b0;
		end
		waitidle;
		jp(16'h0401, 1'b1);
	endtask
	task arith(input logic [5:0] o);
		@(posedge clk_i);
		{ad, aop, ov, cy} <= {1'b1, o, 2'b11};
		@(posedge clk_i);
		ad <= 1'b0;
	endtask
	initial begin
		#100us;
		errors++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 8'h08, 32'h0);
		chk("p_rst", 36'h0, rdq);
		arith(6'h12);
		wb(0, 8'h20, 32'h0);
		chk("flags", 2'b10, rdq[1:0]);
		arith(6'h0c);
		wb(0, 8'h20, 32'h0);
		chk("flags", 2'b11, rdq[1:0]);
		ex(N, 4'h0, 4'h0, 12, 36'h0, 1, 36'h0);
		ex(N, 4'h0, 4'h0, 12, 36'h5, 0, 36'h5);
		ex(N, 4'h1, 4'h0, 12, 36'hfffffffff, 0, 36'hfffffffff);
		ex(N, 4'h1, 4'h0, 12, 36'h5, 1, 36'h5);
		ex(N, 4'h2, 4'h0, 12, 36'h5, 1, 36'h5);
		ex(N, 4'h2, 4'h0, 12, 36'h800000000, 0, 36'h800000000);
		ex(N, 4'h3, 4'h0, 12, 36'h800000000, 1, 36'h800000000);
		ex(N, 4'h3, 4'h0, 12, 36'h5, 0, 36'h5);
		ex(N, 4'h8, 4'h0, 12, 36'h6, 1, 36'h6);
		ex(N, 4'h8, 4'h0, 12, 36'h5, 0, 36'h5);
		ex(N, 4'h9, 4'h0, 12, 36'h5, 1, 36'h5);
		ex(6'h3a, 4'h2, 4'h0, 12, 36'h5, 0, 36'h5);
		wb(0, 8'h00, 32'h0);
		chk("illegal", 1'b1, rdq[3]);
		ex(N, 4'h4, 4'h3, 15, 36'h0, 1, 36'h0);
		ex(N, 4'h4, 4'h5, 17, 36'h0, 0, 36'h0);
		ex(N, 4'h4, 4'h0, 12, 36'h0, 1, 36'h0);
		ex(N, 4'hc, 4'h0, 12, 36'h0, 1, 36'h0);
		ex(N, 4'he, 4'h0, 12, 36'h0, 1, 36'h0);
		ex(N, 4'hf, 4'h0, 12, 36'h0, 0, 36'h0);
		wb(1, 8'h20, 32'h3);
		ex(N, 4'hc, 4'h0, 12, 36'h0, 0, 36'h0);
		ex(N, 4'hf, 4'h0, 12, 36'h0, 1, 36'h0);
		sl <= 1'b1;
		ex(6'h38, 4'h2, 4'h5, 7'h25, 36'h2d, 1, 36'h2c);
		ex(6'h38, 4'h2, 4'h5, 7'h25, 36'h0, 0, 36'hffffffffe);
		ex(6'h3a, 4'h3, 4'h0, 12, 36'h800000001, 1, 36'h3);
		ex(6'h3a, 4'h3, 4'h0, 12, 36'h5, 0, 36'ha);
		ex(N, 4'ha, 4'h2, 2, 36'h0001006db, 1, 36'h0001006df);
		ex(N, 4'ha, 4'h2, 2, 36'h00017ffe1, 0, 36'h00017ffe6);
		ex(N, 4'hb, 4'h3, 3, 36'hfffffffff, 1, 36'hffffc0200);
		ex(N, 4'h5, 4'h1, 13, 36'h0, 1, 36'h0);
		stop_run(4'h2, 1'b0);
		stop_run(4'h0, 1'b1);
		ret(16'h0300);
		chk("waddr", 16'h0300, wa);
		chk("wdata", 36'h200, wd);
		cmw(7'h40, 36'hfffffffff);
		ret(16'h0040);
		cmr(7'h40);
		chk("film", 36'h200, rv);
		chk("fetch", 16'h0041, ra);
		print_verdict;
	end
endmodule
